// File: hw/adcs_top.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "adcs_consts.svh"

// Functional notes
// - Conversions continue through sleep only when the RC conversion clock is selected.
// - With RC clock, conversion starts one instruction cycle after go is set.
// - Completion clears go and loads the result pair.
// - With done interrupt enabled, completion during sleep wakes the device.
// - With done interrupt disabled, device stays asleep; power-on bit stays set.
// - Sleep with non-RC clock aborts conversion, powers converter down, power-on reads set.
// - Any reset restores control registers, powers converter off, aborts conversion.
// - Any reset puts all converter input pins into analog mode.
// - Power-on reset leaves results undefined; other resets keep results.
// - Clearing go mid-conversion aborts it; results keep previous value.
// - After abort wait two conversion clock periods; no new start before then.
// - Ten-bit result is left or right justified per the justify select bit.
// - Six unused result bits are filled with zeros on each completion.
module adcs_top (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device state
    input wire logic dev_reset,
    input wire logic cpu_sleep,
    // converter analog side
    input wire logic [9:0] sample_code,
    output logic converter_enable,
    output logic [2:0] channel_select,
    output logic [3:0] analog_pin_config,
    // events
    output logic irq,
    output logic wake_req
);
    adcs_seq_if sif ();

    adcs_pkg::adcs_byte_t ctrl0_reg;
    adcs_pkg::adcs_byte_t ctrl1_reg;
    logic done_flag_reg;
    logic done_irq_enable_reg;
    adcs_pkg::adcs_byte_t result_high_byte_reg;
    adcs_pkg::adcs_byte_t result_low_byte_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic wake_reg;
    logic enable_reg;

    logic [7:0] index;
    logic hit;
    logic acc;
    logic wr_en;
    logic rd_en;
    logic wr_ctrl0;
    logic rc_sel;
    logic powered;
    logic go_req;
    logic start_ok;
    logic go_clear_req;
    logic abort_now;
    logic [7:0] tad_div;
    logic [15:0] justified;
    adcs_pkg::adcs_byte_t rd_byte;
    logic rd_hit;

    // address decode shared by the read and write paths
    function automatic logic [8:0] adcs_decode(input logic [9:0] addr);
        logic [7:0] idx;
        logic ok;
        idx = addr[9:2];
        ok = (addr[1:0] == 2'h0) && ((idx == `ADCS_IDX_IRQ_FLAGS) || (idx == `ADCS_IDX_RESULT_HIGH) ||
            (idx == `ADCS_IDX_CTRL_PRIMARY) || (idx == `ADCS_IDX_IRQ_ENABLE) ||
            (idx == `ADCS_IDX_RESULT_LOW) || (idx == `ADCS_IDX_CTRL_SECONDARY));
        return {ok, idx};
    endfunction

    function automatic logic [7:0] adcs_tad(input logic [1:0] sel);
        case (sel)
            2'h0: return `ADCS_TAD_DIV_0;
            2'h1: return `ADCS_TAD_DIV_1;
            2'h2: return `ADCS_TAD_DIV_2;
            default: return 8'(`ADCS_RC_TAD_CYCLES);
        endcase
    endfunction

    assign {hit, index} = adcs_decode(paddr);
    // one wait state: the answer comes from flops in the second access cycle
    assign acc = psel && penable && !pready_reg;
    assign wr_en = psel && penable && pready_reg && pwrite && hit;
    assign rd_en = acc && !pwrite;
    assign wr_ctrl0 = wr_en && (index == `ADCS_IDX_CTRL_PRIMARY);

    assign rc_sel = (ctrl0_reg[`ADCS_BIT_CLK_SEL_HI:`ADCS_BIT_CLK_SEL_LO] == `ADCS_CLK_SEL_RC);
    // the power-on bit may read set while the converter itself is down
    assign powered = ctrl0_reg[`ADCS_BIT_POWER_ON] && !(cpu_sleep && !rc_sel);
    assign tad_div = adcs_tad(ctrl0_reg[`ADCS_BIT_CLK_SEL_HI:`ADCS_BIT_CLK_SEL_LO]);

    // go is accepted only when already powered and the post-abort wait is over
    assign go_req = wr_ctrl0 && pwdata[`ADCS_BIT_GO] && !ctrl0_reg[`ADCS_BIT_GO];
    assign start_ok = go_req && ctrl0_reg[`ADCS_BIT_POWER_ON] && pwdata[`ADCS_BIT_POWER_ON] &&
        !sif.busy && !sif.settling;
    assign go_clear_req = wr_ctrl0 && !pwdata[`ADCS_BIT_GO];
    assign abort_now = ctrl0_reg[`ADCS_BIT_GO] && sif.busy &&
        (go_clear_req || !powered || (wr_ctrl0 && !pwdata[`ADCS_BIT_POWER_ON]));

    assign sif.start = start_ok;
    assign sif.abort = abort_now;
    assign sif.rc_mode = rc_sel;
    assign sif.tad_cycles = tad_div;

    // justification with zero fill
    assign justified = ctrl1_reg[`ADCS_BIT_JUSTIFY] ? {6'h00, sample_code} :
        {sample_code, 6'h00};

    always_comb begin
        rd_byte = 8'h00;
        rd_hit = hit;
        case (index)
            `ADCS_IDX_IRQ_FLAGS: rd_byte[`ADCS_BIT_DONE_FLAG] = done_flag_reg;
            `ADCS_IDX_IRQ_ENABLE: rd_byte[`ADCS_BIT_DONE_FLAG] = done_irq_enable_reg;
            `ADCS_IDX_RESULT_HIGH: rd_byte = result_high_byte_reg;
            `ADCS_IDX_RESULT_LOW: rd_byte = result_low_byte_reg;
            `ADCS_IDX_CTRL_PRIMARY: rd_byte = ctrl0_reg;
            `ADCS_IDX_CTRL_SECONDARY: rd_byte = ctrl1_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    adcs_conv_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .dev_reset(dev_reset),
        .sq(sif)
    );

    // apb answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= acc;
            pslverr_reg <= acc && !hit;
            if (rd_en) begin
                prdata_reg <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            end
        end
    end

    // primary control: clock select, channel, go, power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg <= `ADCS_RST_CTRL_PRIMARY;
        end else if (dev_reset) begin
            ctrl0_reg <= `ADCS_RST_CTRL_PRIMARY;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_reg[7:3] <= pwdata[7:3];
                ctrl0_reg[`ADCS_BIT_POWER_ON] <= pwdata[`ADCS_BIT_POWER_ON];
                ctrl0_reg[1] <= 1'b0;
                if (!pwdata[`ADCS_BIT_GO]) begin
                    ctrl0_reg[`ADCS_BIT_GO] <= 1'b0;
                end else if (start_ok) begin
                    ctrl0_reg[`ADCS_BIT_GO] <= 1'b1;
                end
            end
            // completion and non-rc sleep both drop go; power-on is never touched here
            if (sif.done || (abort_now && !go_clear_req)) begin
                ctrl0_reg[`ADCS_BIT_GO] <= 1'b0;
            end
        end
    end

    // secondary control: justification and pin configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_reg <= `ADCS_RST_CTRL_SECONDARY;
        end else if (dev_reset) begin
            ctrl1_reg <= `ADCS_RST_CTRL_SECONDARY;
        end else if (wr_en && (index == `ADCS_IDX_CTRL_SECONDARY)) begin
            ctrl1_reg <= {pwdata[7], 3'h0, pwdata[3:0]};
        end
    end

    // interrupt flag and mask; a completion beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag_reg <= 1'b0;
            done_irq_enable_reg <= 1'b0;
        end else if (dev_reset) begin
            done_flag_reg <= 1'b0;
            done_irq_enable_reg <= 1'b0;
        end else begin
            if (sif.done) begin
                done_flag_reg <= 1'b1;
            end else if (wr_en && (index == `ADCS_IDX_IRQ_FLAGS) && pwdata[`ADCS_BIT_DONE_FLAG]) begin
                done_flag_reg <= 1'b0;
            end
            if (wr_en && (index == `ADCS_IDX_IRQ_ENABLE)) begin
                done_irq_enable_reg <= pwdata[`ADCS_BIT_DONE_FLAG];
            end
        end
    end

    // result pair has no reset so its content is undefined after power-on and kept otherwise
    always_ff @(posedge pclk) begin
        if (sif.done && !dev_reset) begin
            result_high_byte_reg <= justified[15:8];
            result_low_byte_reg <= justified[7:0];
        end else begin
            if (wr_en && !dev_reset && (index == `ADCS_IDX_RESULT_HIGH)) begin
                result_high_byte_reg <= pwdata[7:0];
            end
            if (wr_en && !dev_reset && (index == `ADCS_IDX_RESULT_LOW)) begin
                result_low_byte_reg <= pwdata[7:0];
            end
        end
    end

    // interrupt and wake outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else if (dev_reset) begin
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            irq_reg <= done_flag_reg && done_irq_enable_reg;
            // without enable the device simply stays asleep
            wake_reg <= cpu_sleep && done_flag_reg && done_irq_enable_reg;
        end
    end

    // analog enable follows power-on, dropped in sleep unless rc clocked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= 1'b0;
        end else if (dev_reset) begin
            enable_reg <= 1'b0;
        end else begin
            enable_reg <= powered;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign wake_req = wake_reg;
    assign converter_enable = enable_reg;
    assign channel_select = ctrl0_reg[`ADCS_BIT_CHAN_HI:`ADCS_BIT_CHAN_LO];
    assign analog_pin_config = ctrl1_reg[`ADCS_BIT_PINCFG_HI:`ADCS_BIT_PINCFG_LO];
endmodule

// File: hw/adcs_consts.svh
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

// register indices; byte address is four times the index
`define ADCS_IDX_IRQ_FLAGS 8'h0C
`define ADCS_IDX_RESULT_HIGH 8'h1E
`define ADCS_IDX_CTRL_PRIMARY 8'h1F
`define ADCS_IDX_IRQ_ENABLE 8'h8C
`define ADCS_IDX_RESULT_LOW 8'h9E
`define ADCS_IDX_CTRL_SECONDARY 8'h9F

// field positions
`define ADCS_BIT_DONE_FLAG 6
`define ADCS_BIT_CLK_SEL_HI 7
`define ADCS_BIT_CLK_SEL_LO 6
`define ADCS_BIT_CHAN_HI 5
`define ADCS_BIT_CHAN_LO 3
`define ADCS_BIT_GO 2
`define ADCS_BIT_POWER_ON 0
`define ADCS_BIT_JUSTIFY 7
`define ADCS_BIT_PINCFG_HI 3
`define ADCS_BIT_PINCFG_LO 0

// reset values
`define ADCS_RST_IRQ_FLAGS 8'h00
`define ADCS_RST_IRQ_ENABLE 8'h00
`define ADCS_RST_CTRL_PRIMARY 8'h00
`define ADCS_RST_CTRL_SECONDARY 8'h00
`define ADCS_RST_PINCFG 4'h0

// conversion clock select codes
`define ADCS_CLK_SEL_RC 2'h3

// timing
`define ADCS_PCLK_NS 100
`define ADCS_RC_TAD_NS 4000
`define ADCS_RC_TAD_CYCLES ((`ADCS_RC_TAD_NS + `ADCS_PCLK_NS - 1) / `ADCS_PCLK_NS)
`define ADCS_TAD_DIV_0 8'h02
`define ADCS_TAD_DIV_1 8'h08
`define ADCS_TAD_DIV_2 8'h20
`define ADCS_INSTR_CYCLES 8'h04
`define ADCS_CONV_TADS 4'hC
`define ADCS_SETTLE_TADS 4'h2

`endif

// File: hw/adcs_pkg.sv
package adcs_pkg;

    typedef enum logic [3:0] {
        ADCS_SEQ_IDLE = 4'h1,
        ADCS_SEQ_DELAY = 4'h2,
        ADCS_SEQ_CONV = 4'h4,
        ADCS_SEQ_SETTLE = 4'h8
    } adcs_seq_state_t;

    typedef logic [7:0] adcs_byte_t;

endpackage

// File: hw/adcs_seq_if.sv
`timescale 1ns/1ps

interface adcs_seq_if;
    logic start;
    logic abort;
    logic rc_mode;
    logic [7:0] tad_cycles;
    logic done;
    logic busy;
    logic settling;

    modport ctrl (
        output start,
        output abort,
        output rc_mode,
        output tad_cycles,
        input done,
        input busy,
        input settling
    );

    modport seq (
        input start,
        input abort,
        input rc_mode,
        input tad_cycles,
        output done,
        output busy,
        output settling
    );
endinterface

// File: hw/adcs_conv_seq.sv
`timescale 1ns/1ps
`include "adcs_consts.svh"

module adcs_conv_seq (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dev_reset,
    // control
    adcs_seq_if.seq sq
);
    adcs_pkg::adcs_seq_state_t state_reg;
    logic [7:0] cnt_reg;
    logic [7:0] tad_reg;
    logic [3:0] tads_reg;
    logic done_reg;

    assign sq.done = done_reg;
    assign sq.busy = (state_reg == adcs_pkg::ADCS_SEQ_DELAY) || (state_reg == adcs_pkg::ADCS_SEQ_CONV);
    assign sq.settling = (state_reg == adcs_pkg::ADCS_SEQ_SETTLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= adcs_pkg::ADCS_SEQ_IDLE;
            cnt_reg <= 8'h00;
            tad_reg <= 8'h01;
            tads_reg <= 4'h0;
            done_reg <= 1'b0;
        end else if (dev_reset) begin
            state_reg <= adcs_pkg::ADCS_SEQ_IDLE;
            cnt_reg <= 8'h00;
            tads_reg <= 4'h0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                adcs_pkg::ADCS_SEQ_IDLE: begin
                    if (sq.start) begin
                        tad_reg <= sq.tad_cycles;
                        tads_reg <= 4'h0;
                        if (sq.rc_mode) begin
                            // lets the core issue its sleep before switching noise starts
                            state_reg <= adcs_pkg::ADCS_SEQ_DELAY;
                            cnt_reg <= `ADCS_INSTR_CYCLES - 8'h01;
                        end else begin
                            state_reg <= adcs_pkg::ADCS_SEQ_CONV;
                            cnt_reg <= sq.tad_cycles - 8'h01;
                        end
                    end
                end
                adcs_pkg::ADCS_SEQ_DELAY: begin
                    if (sq.abort) begin
                        state_reg <= adcs_pkg::ADCS_SEQ_SETTLE;
                        cnt_reg <= tad_reg - 8'h01;
                        tads_reg <= 4'h0;
                    end else if (cnt_reg == 8'h00) begin
                        state_reg <= adcs_pkg::ADCS_SEQ_CONV;
                        cnt_reg <= tad_reg - 8'h01;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                adcs_pkg::ADCS_SEQ_CONV: begin
                    if (sq.abort) begin
                        state_reg <= adcs_pkg::ADCS_SEQ_SETTLE;
                        cnt_reg <= tad_reg - 8'h01;
                        tads_reg <= 4'h0;
                    end else if (cnt_reg != 8'h00) begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end else if (tads_reg == `ADCS_CONV_TADS - 4'h1) begin
                        state_reg <= adcs_pkg::ADCS_SEQ_IDLE;
                        done_reg <= 1'b1;
                    end else begin
                        tads_reg <= tads_reg + 4'h1;
                        cnt_reg <= tad_reg - 8'h01;
                    end
                end
                adcs_pkg::ADCS_SEQ_SETTLE: begin
                    if (cnt_reg != 8'h00) begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end else if (tads_reg == `ADCS_SETTLE_TADS - 4'h1) begin
                        state_reg <= adcs_pkg::ADCS_SEQ_IDLE;
                    end else begin
                        tads_reg <= tads_reg + 4'h1;
                        cnt_reg <= tad_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= adcs_pkg::ADCS_SEQ_IDLE;
                end
            endcase
        end
    end
endmodule

// File: testbench/adcs_monitor.sv
`timescale 1ns/1ps
`include "adcs_consts.svh"

module adcs_monitor (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // device state
    input wire logic dev_reset,
    input wire logic cpu_sleep,
    // converter and events
    input wire logic converter_enable,
    input wire logic [2:0] channel_select,
    input wire logic irq,
    input wire logic wake_req
);
    logic ctl0_wr;
    logic rc_sel_reg;

    assign ctl0_wr = psel && penable && pready && pwrite && paddr == {`ADCS_IDX_CTRL_PRIMARY, 2'b00};

    // shadow of the clock select, so the sleep rules can be judged at the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_sel_reg <= 1'b0;
        end else if (dev_reset) begin
            // a device reset also returns the select to its fast setting
            rc_sel_reg <= 1'b0;
        end else if (ctl0_wr) begin
            rc_sel_reg <= pwdata[7:6] == `ADCS_CLK_SEL_RC;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ready_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late pready");
    chk_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
    chk_err_reads_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("bad refusal");
    chk_chan_follows: assert property (ctl0_wr && !dev_reset |=> channel_select == $past(pwdata[5:3]))
        else $error("channel select stale");
    chk_reset_all_off: assert property (dev_reset |=> !converter_enable && channel_select == 3'h0)
        else $error("converter on after reset");
    chk_nonrc_sleep_off: assert property (cpu_sleep && !rc_sel_reg ##1 cpu_sleep && !rc_sel_reg |-> !converter_enable)
        else $error("converter on in sleep");
    chk_rc_sleep_on: assert property (cpu_sleep && rc_sel_reg && converter_enable && !dev_reset && !psel |=> converter_enable)
        else $error("converter dropped in sleep");
    chk_wake_cause: assert property (wake_req |-> irq && $past(cpu_sleep)) else $error("spurious wake");
    chk_wake_prompt: assert property ($rose(irq) && $past(cpu_sleep) |-> wake_req) else $error("missed wake");
endmodule

bind adcs_top adcs_monitor mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_reset(dev_reset),
    .cpu_sleep(cpu_sleep), .converter_enable(converter_enable), .channel_select(channel_select),
    .irq(irq), .wake_req(wake_req)
);

// File: testbench/testbench.sv
`timescale 1ns/1ps
`include "adcs_consts.svh"

module testbench;
    localparam logic [7:0] ctl0 = `ADCS_IDX_CTRL_PRIMARY;
    localparam logic [7:0] ctl1 = `ADCS_IDX_CTRL_SECONDARY;
    localparam logic [7:0] flg = `ADCS_IDX_IRQ_FLAGS;
    localparam logic [7:0] ien = `ADCS_IDX_IRQ_ENABLE;
    localparam logic [7:0] rhi = `ADCS_IDX_RESULT_HIGH;
    localparam logic [7:0] rlo = `ADCS_IDX_RESULT_LOW;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic dev_reset, cpu_sleep, converter_enable, irq, wake_req;
    logic [9:0] paddr, sample_code, code;
    logic [31:0] pwdata, prdata;
    logic [2:0] channel_select;
    logic [3:0] analog_pin_config;
    logic [7:0] res_h, res_l;
    // queued answers: {refused, compare mask, data}
    logic [16:0] exp_q[$];
    logic [16:0] e;
    int errors, checked, cycles, seed, conv_clock_period, n;

    adcs_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dev_reset(dev_reset), .cpu_sleep(cpu_sleep), .sample_code(sample_code),
        .converter_enable(converter_enable), .channel_select(channel_select),
        .analog_pin_config(analog_pin_config), .irq(irq), .wake_req(wake_req)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task test_done;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a hang in the handshake is left to the cycle ceiling
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [7:0] m, input logic er);
        exp_q.push_back({er, m, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 8'h00, 1'b0);
    endtask

    task rd(input logic [7:0] idx, input logic [7:0] d, input logic [7:0] m);
        apb(1'b0, idx, d, m, 1'b0);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, e[16]});
            if (!pwrite)
                check("prdata", prdata & {24'hFFFFFF, e[15:8]}, {24'h0, e[7:0] & e[15:8]});
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, dev_reset, cpu_sleep} = 5'h00;
        paddr = 10'h000;
        pwdata = 32'h0;
        sample_code = 10'h000;
        errors = 0;
        checked = 0;
        cycles = 0;
        seed = 32'h248E6186;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(flg, `ADCS_RST_IRQ_FLAGS, 8'hFF);
        rd(ien, `ADCS_RST_IRQ_ENABLE, 8'hFF);
        rd(ctl0, `ADCS_RST_CTRL_PRIMARY, 8'hFF);
        rd(ctl1, `ADCS_RST_CTRL_SECONDARY, 8'hFF);
        apb(1'b0, 8'h40, 8'h00, 8'hFF, 1'b1);
        apb(1'b1, 8'h40, 8'h5A, 8'h00, 1'b1);
        $display("test register reset done");
        wr(ien, 8'h40);
        // every clock select, justification alternating, the slow one in sleep
        for (int s = 0; s < 4; s++) begin
            code = 10'($random(seed));
            sample_code <= code;
            wr(ctl1, {s[0], 7'h00});
            wr(ctl0, {s[1:0], 6'h29});
            wr(ctl0, {s[1:0], 6'h2D});
            cpu_sleep <= (s == 3);
            conv_clock_period = (s == 0) ? `ADCS_TAD_DIV_0 : (s == 1) ? `ADCS_TAD_DIV_1 :
                  (s == 2) ? `ADCS_TAD_DIV_2 : `ADCS_RC_TAD_CYCLES;
            n = 0;
            while (irq !== 1'b1 && n < 1000) begin
                @(posedge pclk);
                n++;
            end
            // done, then the flag, then the registered irq: two edges after the last conversion step
            check("latency", n, `ADCS_CONV_TADS * conv_clock_period + (s == 3 ? `ADCS_INSTR_CYCLES : 0) + 2);
            check("wake", {31'h0, wake_req}, {31'h0, s == 3});
            cpu_sleep <= 1'b0;
            rd(ctl0, {s[1:0], 6'h29}, 8'hFF);
            rd(flg, 8'h40, 8'h40);
            rd(rhi, s[0] ? {6'h00, code[9:8]} : code[9:2], 8'hFF);
            rd(rlo, s[0] ? code[7:0] : {code[1:0], 6'h00}, 8'hFF);
            wr(flg, 8'h40);
            rd(flg, 8'h00, 8'h40);
            check("irq", {31'h0, irq}, 32'h0);
        end
        $display("test conversions done");
        wr(ien, 8'h00);
        wr(ctl0, 8'hC1);
        wr(ctl0, 8'hC5);
        cpu_sleep <= 1'b1;
        repeat (600) @(posedge pclk);
        check("sleep irq", {30'h0, irq, wake_req}, 32'h0);
        check("power", {31'h0, converter_enable}, 32'h1);
        rd(ctl0, 8'hC1, 8'hFF);
        wr(ien, 8'h40);
        rd(flg, 8'h40, 8'h40);
        check("unmasked", {30'h0, irq, wake_req}, 32'h3);
        cpu_sleep <= 1'b0;
        wr(flg, 8'h40);
        $display("test masked sleep done");
        wr(ctl0, 8'h01);
        wr(ctl0, 8'h05);
        cpu_sleep <= 1'b1;
        repeat (40) @(posedge pclk);
        check("power", {31'h0, converter_enable}, 32'h0);
        rd(ctl0, 8'h01, 8'hFF);
        rd(flg, 8'h00, 8'h40);
        cpu_sleep <= 1'b0;
        $display("test fast clock sleep done");
        res_h = 8'($random(seed));
        res_l = 8'($random(seed));
        wr(rhi, res_h);
        wr(rlo, res_l);
        wr(ctl0, 8'h81);
        wr(ctl0, 8'h85);
        wr(ctl0, 8'h81);
        wr(ctl0, 8'h85);
        rd(ctl0, 8'h81, 8'hFF);
        repeat (400) @(posedge pclk);
        rd(flg, 8'h00, 8'h40);
        wr(ctl0, 8'h85);
        rd(ctl0, 8'h85, 8'hFF);
        // dropping power-on while go stands also aborts and starts the settle wait
        wr(ctl0, 8'h84);
        rd(ctl0, 8'h80, 8'hFF);
        wr(ctl0, 8'h81);
        repeat (80) @(posedge pclk);
        wr(ctl0, 8'h85);
        rd(ctl0, 8'h85, 8'hFF);
        $display("test abort done");
        // device reset lands in the middle of that conversion
        wr(ctl1, 8'h0F);
        check("pins", {28'h0, analog_pin_config}, 32'hF);
        dev_reset <= 1'b1;
        @(posedge pclk);
        dev_reset <= 1'b0;
        @(posedge pclk);
        check("reset pins", {24'h0, converter_enable, analog_pin_config, channel_select}, 32'h0);
        rd(ctl0, 8'h00, 8'hFF);
        rd(ctl1, 8'h00, 8'hFF);
        rd(ien, 8'h00, 8'hFF);
        repeat (400) @(posedge pclk);
        rd(flg, 8'h00, 8'h40);
        rd(rhi, res_h, 8'hFF);
        rd(rlo, res_l, 8'hFF);
        wr(ien, 8'h40);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ien, 8'h00, 8'hFF);
        $display("test resets done");
        test_done();
    end
endmodule
